//--- core/iee_core.sv
// Evaluator for incremental speed sensor 1 with direction and peak limit
// Summary of operation
// RULE1: Mode 0 measures nothing, frees both tracks.
// RULE2: Mode 1 quadrature, phase direction, one edge.
// RULE3: Mode 4 quadrature with direction, four edges.
// RULE4: Modes 11/12 track A only, positive.
// RULE5: Modes 31/32 sign from track B contact.
// RULE6: Modes 101/104 like 1/4, inverted sign.
// RULE7: Modes 111/112 like 11/12, negative.
// RULE8: Mode 131 contact sign inverted, one edge.
// RULE9: Reversal setting swaps setpoint direction mapping.
// RULE10: Reversal changes only while stage disabled.
// RULE11: Reversal inverts motor and encoder sense.
// RULE12: Torque current clamped to peak limit.
// RULE13: Encoder wires track A, track B inputs.
// RULE14: Sensor 1 configured independently of others.
// RULE15: Flag missing encoder signal after 2 ms.
// RULE16: Synchronise tracks, detect edges before counting.
`timescale 1ns/1ps
module iee_core
  import iee_pkg::*;
#(
  parameter int COUNT_WIDTH = 32,
  parameter int CURRENT_WIDTH = 16,
  parameter int TIMEOUT_CYCLES = IEE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic encoder_track_a_input,
  input wire logic encoder_track_b_input,
  input wire logic [10:0] sensor1_mode,
  input wire logic reverse_request,
  input wire logic stage_enabled,
  input wire logic signed [CURRENT_WIDTH-1:0] speed_setpoint,
  input wire logic signed [CURRENT_WIDTH-1:0] torque_current_setpoint,
  input wire logic [23:0] peak_current_limit,
  input wire logic [CURRENT_WIDTH-1:0] inverter_rated_current,
  output logic signed [COUNT_WIDTH-1:0] position_count,
  output logic count_pulse,
  output logic direction_negative,
  output logic signal_timeout,
  output logic mode_invalid,
  output logic track_a_free,
  output logic track_b_free,
  output logic reverse_active,
  output logic reverse_pending,
  output logic signed [CURRENT_WIDTH-1:0] motor_setpoint,
  output logic signed [CURRENT_WIDTH-1:0] torque_current_limited
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int PW = CURRENT_WIDTH + 24;

  // Whole block state
  typedef struct packed {
    logic signed [COUNT_WIDTH-1:0] count;
    logic pulse;
    logic neg;
    logic timeout;
    logic inval;
    logic a_free;
    logic b_free;
    logic rev;
    logic rev_pend;
    logic [TW-1:0] idle_cnt;
    logic signed [CURRENT_WIDTH-1:0] motor;
    logic signed [CURRENT_WIDTH-1:0] iq;
  } iee_state_s;
  iee_state_s state_reg;
  iee_state_s state_next;

  // Synchronised tracks and their edges
  iee_tracks_s trk;
  logic a_level;
  logic b_level;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  // Synchronise tracks before edge detection
  // RULE16: synchronised edge detect
  iee_sync u_sync_a (
    .clk(clk),
    .reset(reset),
    .din(encoder_track_a_input),
    .level(a_level),
    .rise(a_rise),
    .fall(a_fall)
  );
  iee_sync u_sync_b (
    .clk(clk),
    .reset(reset),
    .din(encoder_track_b_input),
    .level(b_level),
    .rise(b_rise),
    .fall(b_fall)
  );

  // Pack both synchronised levels, one driver for the struct
  assign trk = '{a: a_level, b: b_level};

  // Decode mode code into evaluation settings
  // RULE14: sensor 1 own settings
  iee_cfg_s cfg;
  always_comb begin
    cfg = '{src: IEE_SRC_OFF, edges: 3'h0, invert: 1'b0, valid: 1'b1};
    unique case (sensor1_mode)
      // RULE1: off mode
      IEE_MODE_OFF: cfg.src = IEE_SRC_OFF;
      // RULE2: single quadrature
      IEE_MODE_1: cfg = '{src: IEE_SRC_QUAD, edges: 3'h1, invert: 1'b0, valid: 1'b1};
      // RULE3: quadruple quadrature
      IEE_MODE_4: cfg = '{src: IEE_SRC_QUAD, edges: 3'h4, invert: 1'b0, valid: 1'b1};
      // RULE4: positive unsigned
      IEE_MODE_11: cfg = '{src: IEE_SRC_FIXED, edges: 3'h1, invert: 1'b0, valid: 1'b1};
      IEE_MODE_12: cfg = '{src: IEE_SRC_FIXED, edges: 3'h2, invert: 1'b0, valid: 1'b1};
      // RULE5: contact sign
      IEE_MODE_31: cfg = '{src: IEE_SRC_CONTACT, edges: 3'h1, invert: 1'b0, valid: 1'b1};
      IEE_MODE_32: cfg = '{src: IEE_SRC_CONTACT, edges: 3'h2, invert: 1'b0, valid: 1'b1};
      // RULE6: inverted quadrature
      IEE_MODE_101: cfg = '{src: IEE_SRC_QUAD, edges: 3'h1, invert: 1'b1, valid: 1'b1};
      IEE_MODE_104: cfg = '{src: IEE_SRC_QUAD, edges: 3'h4, invert: 1'b1, valid: 1'b1};
      // RULE7: negative unsigned
      IEE_MODE_111: cfg = '{src: IEE_SRC_FIXED, edges: 3'h1, invert: 1'b1, valid: 1'b1};
      IEE_MODE_112: cfg = '{src: IEE_SRC_FIXED, edges: 3'h2, invert: 1'b1, valid: 1'b1};
      // RULE8: inverted contact
      IEE_MODE_131: cfg = '{src: IEE_SRC_CONTACT, edges: 3'h1, invert: 1'b1, valid: 1'b1};
      // Unknown codes act like off and are flagged
      default: cfg.valid = 1'b0;
    endcase
  end

  // Edge qualification and raw sign
  logic step;
  logic step_neg;
  logic sign_neg;
  always_comb begin
    step = 1'b0;
    step_neg = 1'b0;
    unique case (cfg.src)
      IEE_SRC_QUAD: begin
        // Forward when A leads B; A edge with A!=B means B lags
        if (cfg.edges == 3'h4) begin
          step = a_rise | a_fall | b_rise | b_fall;
          step_neg = ((a_rise | a_fall) & (trk.a == trk.b)) |
                     ((b_rise | b_fall) & (trk.a != trk.b));
        end else begin
          step = a_rise;
          step_neg = trk.b;
        end
      end
      IEE_SRC_FIXED: begin
        step = (cfg.edges == 3'h2) ? (a_rise | a_fall) : a_rise;
      end
      IEE_SRC_CONTACT: begin
        step = (cfg.edges == 3'h2) ? (a_rise | a_fall) : a_rise;
        step_neg = trk.b;
      end
      default: begin
        step = 1'b0;
      end
    endcase
    // RULE11: encoder sense follows reversal
    sign_neg = step_neg ^ cfg.invert ^ state_reg.rev;
  end

  // Peak limit as current magnitude
  logic [PW-1:0] prod;
  logic [PW-1:0] lim_wide;
  logic signed [CURRENT_WIDTH:0] lim;
  logic [23:0] peak_eff;
  always_comb begin
    peak_eff = (peak_current_limit < IEE_PEAK_MIN) ? IEE_PEAK_MIN : peak_current_limit;
    prod = PW'(inverter_rated_current) * PW'(peak_eff);
    lim_wide = prod / PW'(IEE_PEAK_FULL_SCALE);
    if (lim_wide > PW'({1'b0, {(CURRENT_WIDTH-1){1'b1}}})) begin
      lim = (CURRENT_WIDTH+1)'({1'b0, {(CURRENT_WIDTH-1){1'b1}}});
    end else begin
      lim = (CURRENT_WIDTH+1)'(lim_wide);
    end
  end

  // Next state of the whole block
  always_comb begin
    state_next = state_reg;
    state_next.pulse = 1'b0;
    state_next.inval = ~cfg.valid;
    // RULE1: free tracks when unused
    state_next.a_free = (cfg.src == IEE_SRC_OFF);
    // RULE4: track B released
    state_next.b_free = (cfg.src == IEE_SRC_OFF) | (cfg.src == IEE_SRC_FIXED);
    // RULE10: change only with stage off
    if (reverse_request != state_reg.rev) begin
      if (!stage_enabled) begin
        state_next.rev = reverse_request;
        state_next.rev_pend = 1'b0;
      end else begin
        state_next.rev_pend = 1'b1;
      end
    end else begin
      state_next.rev_pend = 1'b0;
    end
    if (step) begin
      // Count one step with sign
      state_next.pulse = 1'b1;
      state_next.neg = sign_neg;
      state_next.count = sign_neg ? state_reg.count - COUNT_WIDTH'(1)
                                  : state_reg.count + COUNT_WIDTH'(1);
    end
    // RULE15: 2 ms signal watchdog
    if (step || cfg.src == IEE_SRC_OFF) begin
      state_next.idle_cnt = '0;
      state_next.timeout = 1'b0;
    end else if (state_reg.idle_cnt >= TW'(TIMEOUT_CYCLES)) begin
      state_next.timeout = 1'b1;
    end else begin
      state_next.idle_cnt = state_reg.idle_cnt + TW'(1);
    end
    // RULE9: reversal swaps setpoint sign
    state_next.motor = state_reg.rev ? -speed_setpoint : speed_setpoint;
    // RULE12: clamp torque current
    if ((CURRENT_WIDTH+1)'(torque_current_setpoint) > lim) begin
      state_next.iq = CURRENT_WIDTH'(lim);
    end else if ((CURRENT_WIDTH+1)'(torque_current_setpoint) < -lim) begin
      state_next.iq = CURRENT_WIDTH'(-lim);
    end else begin
      state_next.iq = torque_current_setpoint;
    end
  end

  // Register the block state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign position_count = state_reg.count;
  assign count_pulse = state_reg.pulse;
  assign direction_negative = state_reg.neg;
  assign signal_timeout = state_reg.timeout;
  assign mode_invalid = state_reg.inval;
  assign track_a_free = state_reg.a_free;
  assign track_b_free = state_reg.b_free;
  assign reverse_active = state_reg.rev;
  assign reverse_pending = state_reg.rev_pend;
  assign motor_setpoint = state_reg.motor;
  assign torque_current_limited = state_reg.iq;
endmodule

//--- core/iee_pkg.sv
// Package with constants and carrier types of the incremental encoder evaluator
package iee_pkg;
  // Operation mode codes of speed sensor 1
  localparam logic [10:0] IEE_MODE_OFF = 11'h000;
  localparam logic [10:0] IEE_MODE_1 = 11'h001;
  localparam logic [10:0] IEE_MODE_4 = 11'h004;
  localparam logic [10:0] IEE_MODE_11 = 11'h00B;
  localparam logic [10:0] IEE_MODE_12 = 11'h00C;
  localparam logic [10:0] IEE_MODE_31 = 11'h01F;
  localparam logic [10:0] IEE_MODE_32 = 11'h020;
  localparam logic [10:0] IEE_MODE_101 = 11'h065;
  localparam logic [10:0] IEE_MODE_104 = 11'h068;
  localparam logic [10:0] IEE_MODE_111 = 11'h06F;
  localparam logic [10:0] IEE_MODE_112 = 11'h070;
  localparam logic [10:0] IEE_MODE_131 = 11'h083;
  // Clock and timing
  localparam int IEE_CLK_MHZ = 250;
  localparam int IEE_SIGNAL_TIMEOUT_MS = 2;
  localparam int IEE_TIMEOUT_CYCLES = IEE_SIGNAL_TIMEOUT_MS * 1000 * IEE_CLK_MHZ;
  // Peak current in units of 0.01 percent of inverter rated current
  localparam logic [23:0] IEE_PEAK_MIN = 24'h000001;
  localparam logic [23:0] IEE_PEAK_DEFAULT = 24'h002710;
  localparam int IEE_PEAK_FULL_SCALE = 10000;
  // Decoded evaluation settings
  typedef enum logic [3:0] {
    IEE_SRC_OFF = 4'h1,
    IEE_SRC_QUAD = 4'h2,
    IEE_SRC_FIXED = 4'h4,
    IEE_SRC_CONTACT = 4'h8
  } iee_src_e;
  typedef struct packed {
    iee_src_e src;
    logic [2:0] edges;
    logic invert;
    logic valid;
  } iee_cfg_s;
  // Synchronised track levels
  typedef struct packed {
    logic a;
    logic b;
  } iee_tracks_s;
endpackage

//--- core/iee_sync.sv
// Two-flop synchroniser with edge detection for one track input
`timescale 1ns/1ps
module iee_sync
  import iee_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  // Synchroniser and history state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } iee_sync_s;
  iee_sync_s state_reg;
  iee_sync_s state_next;

  // Shift the input along the chain
  always_comb begin
    state_next = state_reg;
    state_next.s1 = din;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
  end

  // Register the chain
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edges seen only on the synchronised stages
  assign level = state_reg.s2;
  assign rise = state_reg.s2 & ~state_reg.s3;
  assign fall = ~state_reg.s2 & state_reg.s3;
endmodule

//--- tb/iee_encoder_model.sv
// Behavioural encoder with tracks A and B
`timescale 1ns/1ps
module iee_encoder_model (
  input wire logic clk,
  output logic track_a,
  output logic track_b
);
  // Encoder at rest
  initial begin
    track_a = 1'b0;
    track_b = 1'b0;
  end
  // quadrature pair, A leads B forward
  task automatic step(input logic back, input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clk);
      if ((track_a == track_b) ^ back) begin
        track_a <= !track_a;
      end else begin
        track_b <= !track_b;
      end
    end
  endtask
  // Edges on track A alone
  task automatic pulse_a(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clk);
      track_a <= !track_a;
    end
  endtask
  // Direction contact level on track B
  task automatic set_b(input logic lvl);
    @(posedge clk);
    track_b <= lvl;
  endtask
endmodule

//--- tb/iee_monitor.sv
// Port checker for the encoder evaluator
`timescale 1ns/1ps
module iee_monitor
  import iee_pkg::*;
#(
  parameter int COUNT_WIDTH = 32,
  parameter int CURRENT_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [10:0] sensor1_mode,
  input wire logic reverse_request,
  input wire logic stage_enabled,
  input wire logic signed [CURRENT_WIDTH-1:0] speed_setpoint,
  input wire logic signed [COUNT_WIDTH-1:0] position_count,
  input wire logic count_pulse,
  input wire logic direction_negative,
  input wire logic signal_timeout,
  input wire logic track_a_free,
  input wire logic track_b_free,
  input wire logic reverse_active,
  input wire logic reverse_pending,
  input wire logic signed [CURRENT_WIDTH-1:0] motor_setpoint
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Mode groups
  wire logic is_off = sensor1_mode == IEE_MODE_OFF;
  wire logic is_pos = sensor1_mode inside {IEE_MODE_11, IEE_MODE_12};
  wire logic is_neg = sensor1_mode inside {IEE_MODE_111, IEE_MODE_112};
  a_pulse_single:
    assert property (count_pulse |=> !count_pulse) else $error("pulse too long");
  a_count_step:
    assert property (count_pulse |-> position_count == $past(position_count)
      + (direction_negative ? -32'sd1 : 32'sd1)) else $error("count step wrong");
  a_off_idle:
    assert property (is_off [*4] |-> !count_pulse) else $error("count while off");
  a_off_free:
    assert property (is_off |=> track_a_free && track_b_free) else $error("tracks held");
  a_fixed_pos:
    assert property (is_pos [*4] ##0 count_pulse |->
      direction_negative == $past(reverse_active))
      else $error("fixed positive sign wrong");
  a_fixed_neg:
    assert property (is_neg [*4] ##0 count_pulse |->
      direction_negative != $past(reverse_active))
      else $error("fixed negative sign wrong");
  a_rev_stage:
    assert property ($changed(reverse_active) |-> !$past(stage_enabled))
      else $error("reversal changed with stage on");
  a_rev_pending:
    assert property (stage_enabled && reverse_request != reverse_active |=> reverse_pending)
      else $error("pending not flagged");
  a_motor_sign:
    assert property (!$past(reset) |-> motor_setpoint == ($past(reverse_active) ?
      -$past(speed_setpoint) : $past(speed_setpoint))) else $error("setpoint sign wrong");
  c_neg_count: cover property (count_pulse && direction_negative);
  c_pending: cover property (reverse_pending);
  c_timeout: cover property (signal_timeout);
endmodule
bind iee_core iee_monitor #(.COUNT_WIDTH(COUNT_WIDTH), .CURRENT_WIDTH(CURRENT_WIDTH))
  mon_u (
    .clk(clk),
    .reset(reset),
    .sensor1_mode(sensor1_mode),
    .reverse_request(reverse_request),
    .stage_enabled(stage_enabled),
    .speed_setpoint(speed_setpoint),
    .position_count(position_count),
    .count_pulse(count_pulse),
    .direction_negative(direction_negative),
    .signal_timeout(signal_timeout),
    .track_a_free(track_a_free),
    .track_b_free(track_b_free),
    .reverse_active(reverse_active),
    .reverse_pending(reverse_pending),
    .motor_setpoint(motor_setpoint)
  );

//--- tb/testbench.sv
// Self-checking bench for the encoder evaluator
`timescale 1ns/1ps
module testbench;
  import iee_pkg::*;
  localparam int TMO = 50;
  logic clk = 1'b0, reset = 1'b1, reverse_request = 1'b0, stage_enabled = 1'b0;
  logic encoder_track_a_input, encoder_track_b_input, count_pulse, direction_negative;
  logic signal_timeout, mode_invalid, track_a_free, track_b_free;
  logic reverse_active, reverse_pending;
  logic [10:0] sensor1_mode = IEE_MODE_OFF;
  logic signed [15:0] speed_setpoint = 16'sh0000, torque_current_setpoint = 16'sh0000;
  logic signed [15:0] motor_setpoint, torque_current_limited;
  logic [23:0] peak_current_limit = IEE_PEAK_DEFAULT;
  logic [15:0] inverter_rated_current = 16'h03E8;
  logic signed [31:0] position_count;
  int num_errors = 0, samples_checked = 0;
  iee_core #(.TIMEOUT_CYCLES(TMO)) dut_u (
    .clk(clk),
    .reset(reset),
    .encoder_track_a_input(encoder_track_a_input),
    .encoder_track_b_input(encoder_track_b_input),
    .sensor1_mode(sensor1_mode),
    .reverse_request(reverse_request),
    .stage_enabled(stage_enabled),
    .speed_setpoint(speed_setpoint),
    .torque_current_setpoint(torque_current_setpoint),
    .peak_current_limit(peak_current_limit),
    .inverter_rated_current(inverter_rated_current),
    .position_count(position_count),
    .count_pulse(count_pulse),
    .direction_negative(direction_negative),
    .signal_timeout(signal_timeout),
    .mode_invalid(mode_invalid),
    .track_a_free(track_a_free),
    .track_b_free(track_b_free),
    .reverse_active(reverse_active),
    .reverse_pending(reverse_pending),
    .motor_setpoint(motor_setpoint),
    .torque_current_limited(torque_current_limited)
  );
  iee_encoder_model enc_u (.clk(clk), .track_a(encoder_track_a_input),
    .track_b(encoder_track_b_input));
  // Free-running clock
  initial forever #2 clk = ~clk;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Select a mode and let it settle
  task automatic use_mode(input logic [10:0] m);
    @(posedge clk);
    sensor1_mode <= m;
    repeat (4) @(posedge clk);
  endtask
  // Count change and sign after edges settle
  task automatic settle(input logic [31:0] base, input logic [31:0] d, input logic ng);
    repeat (6) @(posedge clk);
    check(position_count - base, d);
    check(direction_negative, ng);
  endtask
  task automatic t_off();
    logic [31:0] b;
    use_mode(IEE_MODE_OFF);
    b = position_count;
    enc_u.pulse_a(4, 4);
    enc_u.step(1'b0, 4, 3);
    repeat (6) @(posedge clk);
    check(position_count - b, 32'h0);
    check({track_a_free, track_b_free}, 2'h3);
    use_mode(11'h002);
    check(mode_invalid, 1'b1);
    b = position_count;
    enc_u.pulse_a(4, 4);
    repeat (6) @(posedge clk);
    check(position_count - b, 32'h0);
    use_mode(IEE_MODE_OFF);
    check(mode_invalid, 1'b0);
    $display("test off done");
  endtask
  task automatic t_quad();
    logic [10:0] m [4] = '{IEE_MODE_1, IEE_MODE_4, IEE_MODE_101, IEE_MODE_104};
    logic [31:0] d [4] = '{32'h2, 32'hFFFFFFF8, 32'hFFFFFFFE, 32'h8};
    logic [31:0] b;
    for (int i = 0; i < 4; i++) begin
      use_mode(m[i]);
      b = position_count;
      enc_u.step(i[0], 8, 4);
      settle(b, d[i], i[0] ^ i[1]);
    end
    $display("test quadrature done");
  endtask
  task automatic t_track_a();
    logic [10:0] m [4] = '{IEE_MODE_11, IEE_MODE_12, IEE_MODE_111, IEE_MODE_112};
    logic [31:0] d [4] = '{32'h2, 32'h4, 32'hFFFFFFFE, 32'hFFFFFFFC};
    logic [31:0] b;
    for (int i = 0; i < 4; i++) begin
      use_mode(m[i]);
      b = position_count;
      enc_u.pulse_a(4, 4);
      settle(b, d[i], i[1]);
      check({track_a_free, track_b_free}, 2'h1);
    end
    $display("test track a done");
  endtask
  task automatic t_contact();
    logic [10:0] m [5] = '{IEE_MODE_31, IEE_MODE_31, IEE_MODE_32, IEE_MODE_131, IEE_MODE_131};
    logic [31:0] d [5] = '{32'h2, 32'hFFFFFFFE, 32'hFFFFFFFC, 32'hFFFFFFFE, 32'h2};
    logic [4:0] bl = 5'h16;
    logic [4:0] ng = 5'h0E;
    logic [31:0] b;
    for (int i = 0; i < 5; i++) begin
      enc_u.set_b(bl[i]);
      use_mode(m[i]);
      b = position_count;
      enc_u.pulse_a(4, 4);
      settle(b, d[i], ng[i]);
    end
    $display("test contact done");
  endtask
  task automatic t_reverse();
    logic [31:0] b;
    use_mode(IEE_MODE_11);
    @(posedge clk);
    stage_enabled <= 1'b1;
    speed_setpoint <= 16'sh0123;
    reverse_request <= 1'b1;
    repeat (3) @(posedge clk);
    check({reverse_active, reverse_pending}, 2'h1);
    check(motor_setpoint, 32'h0123);
    stage_enabled <= 1'b0;
    repeat (3) @(posedge clk);
    check({reverse_active, reverse_pending}, 2'h2);
    check(motor_setpoint, 32'hFFFFFEDD);
    b = position_count;
    enc_u.pulse_a(4, 4);
    settle(b, 32'hFFFFFFFE, 1'b1);
    reverse_request <= 1'b0;
    repeat (3) @(posedge clk);
    $display("test reverse done");
  endtask
  task automatic t_clamp();
    logic [23:0] pk [4] = '{24'h002710, 24'h002710, 24'h001388, 24'h001388};
    logic signed [15:0] tq [4] = '{16'sh0BB8, 16'shF448, 16'sh0BB8, 16'sh00C8};
    logic [31:0] ex [4] = '{32'h3E8, 32'hFFFFFC18, 32'h1F4, 32'hC8};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      peak_current_limit <= pk[i];
      torque_current_setpoint <= tq[i];
      repeat (3) @(posedge clk);
      check(torque_current_limited, ex[i]);
    end
    $display("test clamp done");
  endtask
  task automatic t_timeout();
    use_mode(IEE_MODE_11);
    enc_u.pulse_a(2, 4);
    repeat (TMO + 12) @(posedge clk);
    check(signal_timeout, 1'b1);
    enc_u.pulse_a(2, 4);
    repeat (6) @(posedge clk);
    check(signal_timeout, 1'b0);
    $display("test timeout done");
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_off();
    t_quad();
    t_track_a();
    t_contact();
    t_reverse();
    t_clamp();
    t_timeout();
    tally_and_finish();
  end
  // Watchdog against a hung run
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
